/* core/brrs_pkg.sv */
// Package: packet codes, option bit, counts for the RAM readback link
package brrs_pkg;
  localparam logic [31:0] HDR_CMD_WR = 32'h3000_8001;
  localparam logic [31:0] HDR_OPT_RD = 32'h2801_2001;
  localparam logic [31:0] HDR_OPT_WR = 32'h3001_2001;
  localparam logic [31:0] HDR_FAR_WR = 32'h3000_2001;
  localparam logic [31:0] HDR_FRAME_DATA_OUTPUT_REG_RD = 32'h2800_6000;
  localparam logic [31:0] CMD_START = 32'h0000_0005;
  localparam logic [31:0] CMD_CRC_RESET = 32'h0000_0007;
  localparam logic [31:0] CMD_READBACK = 32'h0000_0004;
  localparam logic [31:0] DUMMY_WORD = 32'hffff_ffff;
  localparam logic [31:0] SYNC_WORD = 32'haa99_5566;
  localparam logic [7:0] TYPE2_CODE = 8'h48;
  localparam logic [31:0] FAR_COL0 = 32'h0200_0000;
  localparam logic [31:0] FAR_COL1 = 32'h0202_0000;
  localparam int SHUTDOWN_BIT = 15;
  localparam int FLUSH_CLOCKS = 8;
  localparam int COLUMN_FRAMES = 65;
  localparam int PAD_BITS = 32;
  localparam logic [31:0] OPT_RESET = 32'h0000_0000;
  localparam logic [10:0] WORD_COUNT_DEF = 11'h30c;
endpackage : brrs_pkg

/* core/brrs_if.sv */
// Interface: parallel configuration port between controller and device
interface brrs_if;
  logic cclk;
  logic cs;
  logic wr;
  logic [31:0] d_ctl;
  logic d_ctl_oe;
  logic [31:0] d_dev;
  logic d_dev_oe;
  logic busy;
  wire [31:0] d = d_ctl_oe ? d_ctl : (d_dev_oe ? d_dev : '1);
  modport ctl (output cclk, output cs, output wr, output d_ctl,
    output d_ctl_oe, input d_dev, input d_dev_oe, input busy);
  modport dev (input cclk, input cs, input wr, input d_ctl,
    input d_ctl_oe, output d_dev, output d_dev_oe, output busy);
endinterface : brrs_if

/* core/brrs_device.sv */
// Device end: packet decoder, shutdown/start-up, RAM column readback
module brrs_device #(
  parameter int WORDS = 780
) (
  input wire logic clk,
  input wire logic reset,
  brrs_if.dev port,
  output logic user_enable,
  output logic ram_cfg_owner,
  output logic [31:0] ram_addr,
  input wire logic [31:0] ram_rdata
);
  if (WORDS < 1 || WORDS > 2047) begin : g_bad_words
    $error("WORDS out of range");
  end
  typedef enum {BRRS_HDR, BRRS_DATA, BRRS_T2, BRRS_OUT} brrs_st_t;
  brrs_st_t st_r;
  logic [2:0] ck_s;
  logic cs_s1_r, cs_s2_r, wr_s1_r, wr_s2_r;
  logic [31:0] d_s1_r, d_s2_r;
  logic [31:0] hdr_r, opt_r, far_r;
  logic [10:0] cnt_r;
  logic [3:0] flush_r;
  logic shut_pend_r;
  logic [31:0] dout_r;
  logic out_r;
  logic cclk_rise;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      ck_s <= 3'h0;
      cs_s1_r <= 1'b0;
      cs_s2_r <= 1'b0;
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      d_s1_r <= 32'h0;
      d_s2_r <= 32'h0;
    end else begin
      ck_s <= {ck_s[1:0], port.cclk};
      cs_s1_r <= port.cs;
      cs_s2_r <= cs_s1_r;
      wr_s1_r <= port.wr;
      wr_s2_r <= wr_s1_r;
      d_s1_r <= port.d_ctl;
      d_s2_r <= d_s1_r;
    end
  end
  // Edge found on the second and third stages only
  assign cclk_rise = ck_s[1] & ~ck_s[2];
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= BRRS_HDR;
      hdr_r <= 32'h0;
      opt_r <= brrs_pkg::OPT_RESET;
      far_r <= 32'h0;
      cnt_r <= 11'h0;
      dout_r <= 32'h0;
      out_r <= 1'b0;
    end else if (cclk_rise && cs_s2_r) begin
      case (st_r)
        BRRS_HDR: begin
          out_r <= 1'b0;
          if (!wr_s2_r && d_s2_r == brrs_pkg::HDR_OPT_RD) begin
            dout_r <= opt_r;
            out_r <= 1'b1;
          end else if (!wr_s2_r && d_s2_r == brrs_pkg::HDR_FRAME_DATA_OUTPUT_REG_RD) begin
            st_r <= BRRS_T2;
          end else if (!wr_s2_r && (d_s2_r == brrs_pkg::HDR_OPT_WR
              || d_s2_r == brrs_pkg::HDR_CMD_WR
              || d_s2_r == brrs_pkg::HDR_FAR_WR)) begin
            hdr_r <= d_s2_r;
            st_r <= BRRS_DATA;
          end
        end
        BRRS_DATA: begin
          st_r <= BRRS_HDR;
          if (hdr_r == brrs_pkg::HDR_OPT_WR) opt_r <= d_s2_r;
          else if (hdr_r == brrs_pkg::HDR_FAR_WR) far_r <= d_s2_r;
        end
        BRRS_T2: begin
          if (d_s2_r[31:24] == brrs_pkg::TYPE2_CODE) begin
            cnt_r <= d_s2_r[10:0];
            st_r <= BRRS_OUT;
          end else st_r <= BRRS_HDR;
        end
        BRRS_OUT: begin
          if (cnt_r == 11'h0) begin
            st_r <= BRRS_HDR;
            out_r <= 1'b0;
          end else begin
            // Frames follow CLB frames; address counts on from far
            dout_r <= ram_rdata;
            out_r <= 1'b1;
            far_r <= far_r + 32'h1;
            cnt_r <= cnt_r - 11'h1;
          end
        end
        default: st_r <= BRRS_HDR;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // Start command arms shutdown or start-up; ten clocks finish it
  always_ff @(posedge clk) begin
    if (reset) begin
      flush_r <= 4'h0;
      shut_pend_r <= 1'b0;
      user_enable <= 1'b1;
    end else if (cclk_rise) begin
      if (cs_s2_r && st_r == BRRS_DATA && hdr_r == brrs_pkg::HDR_CMD_WR
          && d_s2_r == brrs_pkg::CMD_START) begin
        shut_pend_r <= opt_r[brrs_pkg::SHUTDOWN_BIT];
        flush_r <= 4'(brrs_pkg::FLUSH_CLOCKS + 2);
      end else if (flush_r != 4'h0) begin
        flush_r <= flush_r - 4'h1;
        // One sequence; direction set by the option bit
        if (flush_r == 4'h1) user_enable <= ~shut_pend_r;
      end
    end
  end
  // Hand RAM to config logic while reading it out; user writes must stop
  assign ram_cfg_owner = (st_r == BRRS_OUT) | ~user_enable;
  // Column numbering rides in the start frame address
  assign ram_addr = far_r;
  assign port.d_dev = dout_r;
  // Drive only in a read slot; the controller owns the bus otherwise
  assign port.d_dev_oe = out_r & wr_s2_r;
  assign port.busy = (flush_r != 4'h0);
endmodule : brrs_device

/* core/brrs_ctrl.sv */
// Controller end: issues shutdown, column readbacks, start-up
module brrs_ctrl #(
  parameter int WORDS = 780,
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic reset,
  brrs_if.ctl port,
  input wire logic go,
  output logic done,
  output logic [31:0] rdata,
  output logic rvalid
);
  // Below three the device sees a rise after the next word is launched
  if (DIV < 3 || DIV > 256 || WORDS < 1 || WORDS > 2047) begin : g_bad_prm
    $error("bad params");
  end
  logic [7:0] div_r;
  logic tick;
  logic rise;
  logic [5:0] idx_r;
  logic [10:0] wc_r;
  logic busy_r, col_r;
  logic [31:0] opt_r;
  logic [31:0] w;
  logic rd;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= 8'h0;
      port.cclk <= 1'b0;
    end else begin
      div_r <= (div_r == 8'(DIV - 1)) ? 8'h0 : div_r + 8'h1;
      if (div_r == 8'(DIV - 1)) port.cclk <= ~port.cclk;
    end
  end
  assign tick = (div_r == 8'(DIV - 1)) & port.cclk; // falling edge
  assign rise = (div_r == 8'(DIV - 1)) & ~port.cclk; // rising edge
  ////////////////////////////////////////////////////////////////
  always_comb begin
    rd = 1'b0;
    case (idx_r)
      6'd0: w = brrs_pkg::SYNC_WORD;
      6'd1: w = brrs_pkg::HDR_OPT_RD;
      6'd2, 6'd17: begin
        w = 32'h0;
        rd = 1'b1;
      end
      6'd3, 6'd18: w = brrs_pkg::HDR_OPT_WR;
      6'd4: w = opt_r | (32'h1 << brrs_pkg::SHUTDOWN_BIT);
      6'd5, 6'd7, 6'd13, 6'd20, 6'd22: w = brrs_pkg::HDR_CMD_WR;
      6'd6, 6'd21: w = brrs_pkg::CMD_START;
      6'd8, 6'd23: w = brrs_pkg::CMD_CRC_RESET;
      6'd9, 6'd10, 6'd24, 6'd25: w = brrs_pkg::DUMMY_WORD;
      6'd11: w = brrs_pkg::HDR_FAR_WR;
      6'd12: w = col_r ? brrs_pkg::FAR_COL1 : brrs_pkg::FAR_COL0;
      6'd14: w = brrs_pkg::CMD_READBACK;
      6'd15: w = brrs_pkg::HDR_FRAME_DATA_OUTPUT_REG_RD;
      6'd16: w = {brrs_pkg::TYPE2_CODE, 13'h0, 11'(WORDS)};
      6'd19: w = opt_r & ~(32'h1 << brrs_pkg::SHUTDOWN_BIT);
      default: w = brrs_pkg::DUMMY_WORD;
    endcase
  end
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_r <= 6'd0;
      busy_r <= 1'b0;
      col_r <= 1'b0;
      wc_r <= 11'h0;
      opt_r <= 32'h0;
      done <= 1'b0;
      rdata <= 32'h0;
      rvalid <= 1'b0;
      port.cs <= 1'b0;
      port.wr <= 1'b0;
      port.d_ctl <= 32'h0;
      port.d_ctl_oe <= 1'b0;
    end else begin
      rvalid <= 1'b0;
      done <= 1'b0;
      // Device answers a read slot before the next rise and lets go after
      if (busy_r && rise && port.wr && port.d_dev_oe) begin
        rdata <= port.d_dev;
        rvalid <= 1'b1;
        if (idx_r == 6'd3) opt_r <= port.d_dev;
      end
      if (!busy_r && go) begin
        busy_r <= 1'b1;
        idx_r <= 6'd0;
        col_r <= 1'b0;
      end else if (busy_r && tick && idx_r == 6'd11 && port.busy) begin
        // Clock keeps running deselected until the flush is over
        port.cs <= 1'b0;
        port.wr <= 1'b0;
        port.d_ctl_oe <= 1'b0;
      end else if (busy_r && tick) begin
        port.cs <= 1'b1;
        port.wr <= rd;
        port.d_ctl <= w;
        port.d_ctl_oe <= ~rd;
        // One extra read slot: each answer is taken one slot late
        if (idx_r == 6'd17 && wc_r != 11'(WORDS)) begin
          wc_r <= wc_r + 11'h1;
        end else if (idx_r == 6'd17) begin
          wc_r <= 11'h0;
          col_r <= 1'b1;
          idx_r <= col_r ? 6'd18 : 6'd11;
        end else if (idx_r == 6'd26) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          port.cs <= 1'b0;
          port.d_ctl_oe <= 1'b0;
        end else begin
          idx_r <= idx_r + 6'd1;
        end
      end
    end
  end
endmodule : brrs_ctrl

/* bench/brrs_asserts.sv */
// Checker: timing and framing properties of the configuration port
module brrs_asserts #(
  parameter int WORDS = 780
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cclk,
  input wire logic cs,
  input wire logic wr,
  input wire logic [31:0] d_ctl,
  input wire logic d_ctl_oe,
  input wire logic d_dev_oe,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_no_fight: assert property (!(d_ctl_oe && d_dev_oe))
    else $error("both ends drive the data bus");
  chk_cclk_high: assert property ($rose(cclk) |=> cclk[*3])
    else $error("link clock high phase too short");
  chk_read_drive: assert property (d_dev_oe |-> cs && wr)
    else $error("device drives data outside a read");
  chk_ctl_write: assert property (d_ctl_oe |-> !wr)
    else $error("controller drives data during a read");
  chk_reset_idle: assert property ($fell(reset) |-> !cs && !busy)
    else $error("port not idle after reset");
  chk_data_held: assert property ($rose(cclk) && d_ctl_oe |-> $stable(d_ctl))
    else $error("word changed at link clock rise");
  chk_busy_min: assert property ($rose(busy) |-> busy[*8])
    else $error("flush shorter than eight cycles");
  chk_busy_max: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("flush never ends");
  chk_type2_count: assert property (cs && d_ctl_oe && d_ctl[31:24] == 8'h48
    |-> d_ctl[10:0] == 11'(WORDS))
    else $error("type-2 word count wrong");
endmodule : brrs_asserts

/* bench/block_ram_readback_sequencer_tb.sv */
// Testbench: controller and device joined for a two-column RAM readback of four words each
module block_ram_readback_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WORDS = 4;
  localparam logic [31:0] PAT = 32'h5a3c_0f96;
  logic clk, reset, go, done, rvalid, user_enable, ram_cfg_owner, cclk_q;
  logic [31:0] rdata, ram_addr, ram_rdata;
  logic [31:0] seen[$];
  logic [31:0] exp_q[$];
  int errors, checks, nread;
  logic saw_off, saw_own, bad_on;
  brrs_if bus();
  brrs_ctrl #(.WORDS(WORDS)) u_brrs_ctrl (.clk, .reset, .port(bus.ctl),
    .go, .done, .rdata, .rvalid);
  brrs_device #(.WORDS(WORDS)) u_brrs_device (.clk, .reset,
    .port(bus.dev), .user_enable, .ram_cfg_owner, .ram_addr, .ram_rdata);
  brrs_asserts #(.WORDS(WORDS)) u_brrs_asserts (.clk, .reset,
    .cclk(bus.cclk), .cs(bus.cs), .wr(bus.wr), .d_ctl(bus.d_ctl),
    .d_ctl_oe(bus.d_ctl_oe), .d_dev_oe(bus.d_dev_oe), .busy(bus.busy));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Sample off the active edge so design updates have landed
  always @(negedge clk) begin
    cclk_q <= bus.cclk;
    if (bus.cclk && !cclk_q && bus.cs && bus.d_ctl_oe)
      seen.push_back(bus.d_ctl);
    if (rvalid === 1'b1 && rdata === PAT) begin
      nread++;
      if (user_enable !== 1'b0) bad_on = 1;
    end
    if (user_enable === 1'b0) saw_off = 1;
    if (ram_cfg_owner === 1'b1) saw_own = 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic push_cmds();
    exp_q = {exp_q, brrs_pkg::HDR_CMD_WR, brrs_pkg::CMD_START,
      brrs_pkg::HDR_CMD_WR, brrs_pkg::CMD_CRC_RESET,
      brrs_pkg::DUMMY_WORD, brrs_pkg::DUMMY_WORD};
  endtask : push_cmds
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    check("user enable", user_enable, 1);
    check("busy", bus.busy, 0);
  endtask : t_reset_state
  task automatic t_readback_run();
    int n;
    logic [31:0] col[2];
    col = '{brrs_pkg::FAR_COL0, brrs_pkg::FAR_COL1};
    // Option read returns the reset value, so bit 15 is the only change
    exp_q = {brrs_pkg::SYNC_WORD, brrs_pkg::HDR_OPT_RD, brrs_pkg::HDR_OPT_WR,
      brrs_pkg::OPT_RESET | (32'h1 << brrs_pkg::SHUTDOWN_BIT)};
    push_cmds();
    foreach (col[i])
      exp_q = {exp_q, brrs_pkg::HDR_FAR_WR, col[i], brrs_pkg::HDR_CMD_WR,
        brrs_pkg::CMD_READBACK, brrs_pkg::HDR_FRAME_DATA_OUTPUT_REG_RD,
        32'h4800_0000 | 32'(WORDS)};
    exp_q = {exp_q, brrs_pkg::HDR_OPT_WR, brrs_pkg::OPT_RESET};
    push_cmds();
    @(posedge clk) go <= 1;
    @(posedge clk) go <= 0;
    for (n = 0; n < 20000 && done !== 1'b1; n++) @(negedge clk);
    check("done", done, 1);
    for (n = 0; n < 400 && user_enable !== 1'b1; n++) @(negedge clk);
    check("user back on", user_enable, 1);
    check("word total", 32'(seen.size()), 32'(exp_q.size()));
    foreach (exp_q[i])
      check("wire word", seen[i], exp_q[i]);
    check("ram words", 32'(nread), 32'(2 * WORDS));
    check("ram address", ram_addr, brrs_pkg::FAR_COL1 + 32'(WORDS));
    check("user off", saw_off, 1);
    check("ram to config", saw_own, 1);
    check("user on in read", bad_on, 0);
  endtask : t_readback_run
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {errors, checks, nread} = 0;
    {saw_off, saw_own, bad_on, cclk_q} = 0;
    reset = 1;
    go = 0;
    ram_rdata = PAT;
    repeat (5) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    t_reset_state();
    t_readback_run();
    summarize();
  end
  // Run needs about four hundred cycles; allow fifty times that
  initial begin
    #800000;
    errors++;
    summarize();
  end
endmodule : block_ram_readback_sequencer_tb
